/* File: design/hbdc_host_bridge.v */
`include "hbdc_defines.vh"
`include "hbdc_rst_defines.vh"

module hbdc_host_bridge (
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // Configuration access port, byte address of a dword
  input  wire        cfg_wr_in,
  input  wire        cfg_rd_in,
  input  wire [7:0]  cfg_addr_in,
  input  wire [3:0]  cfg_be_in,
  input  wire [31:0] cfg_wdata_in,
  output reg  [31:0] cfg_rdata_out,
  output reg         cfg_rd_valid_out,
  // Lock from the system management RAM control register
  input  wire        smm_lock_in,
  // Straps, sampled from pins
  input  wire        serial_digital_video_strap_in,
  input  wire        concurrent_op_strap_in,
  // Memory access to be decoded
  input  wire        acc_valid_in,
  input  wire [31:0] acc_addr_in,
  input  wire        acc_write_in,
  input  wire [1:0]  acc_src_in,
  output reg         acc_done_out,
  output reg         rc_window_hit_out,
  output reg         legacy_hit_out,
  output reg         legacy_to_dram_out,
  output reg         legacy_to_link_out,
  // Steering outputs toward the decode logic
  output reg         vga_claim_out,
  output reg  [7:0]  gfx_subclass_out,
  output reg  [2:0]  stolen_mem_size_out,
  output reg         gfx_func0_visible_out,
  output reg         gfx_func1_visible_out,
  output reg         gfx_port_visible_out
);

  // Stored register fields; only writable bits have flops
  reg [19:0] link_rc_base;
  reg        link_rc_window_en;
  reg [2:0]  stolen_mem_size;
  reg        vga_claim_disable;
  reg        gfx_func1_enable;
  reg        gfx_func0_enable;
  reg        gfx_port_enable;
  reg [1:0]  attr0_hi;
  reg [1:0]  attr1_hi;
  reg [1:0]  attr1_lo;
  reg [1:0]  attr2_hi;
  reg [1:0]  attr2_lo;
  reg [1:0]  attr3_hi;
  reg [1:0]  attr3_lo;

  // Strap capture state
  reg  [1:0] strap_cnt;
  reg        strap_done;
  wire       serial_digital_video_sync;
  wire       conc_sync;

  // Reassembled register images
  wire [31:0] rc_base_img;
  wire [15:0] gfx_ctrl_img;
  wire [31:0] dev_en_img;
  wire [7:0]  map0_img;
  wire [7:0]  map1_img;
  wire [7:0]  map2_img;
  wire [7:0]  map3_img;

  // Write strobes per register
  wire wr_base;
  wire wr_gfx;
  wire wr_dev;
  wire wr_map;

  // Segment steering result
  wire seg_legacy;
  wire seg_known;
  wire seg_dram;
  wire gfx_vga_off;

  // Compare the dword part of a byte address with a register offset
  function dw_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      dw_hit = (addr[7:2] == off[7:2]);
    end
  endfunction

  // Byte lane of a register inside its dword
  function [1:0] lane_of;
    input [7:0] off;
    begin
      lane_of = off[1:0];
    end
  endfunction

  assign wr_base = cfg_wr_in & dw_hit(cfg_addr_in, `HBDC_OFF_RC_BASE);
  assign wr_gfx  = cfg_wr_in & dw_hit(cfg_addr_in, `HBDC_OFF_GFX_CTRL);
  assign wr_dev  = cfg_wr_in & dw_hit(cfg_addr_in, `HBDC_OFF_DEV_EN);
  assign wr_map  = cfg_wr_in & dw_hit(cfg_addr_in, `HBDC_OFF_ATTR_MAP_0);

  // Reserved bits are built in as zero, so writes to them change nothing
  assign rc_base_img = {link_rc_base, 11'h000, link_rc_window_en};
  assign gfx_ctrl_img = {9'h000, stolen_mem_size, 2'h0,
                         vga_claim_disable, 1'b0};
  assign dev_en_img = {27'h000_0000, gfx_func1_enable, gfx_func0_enable,
                       1'b0, gfx_port_enable, 1'b1};
  assign map0_img = {2'h0, attr0_hi, 4'h0};
  assign map1_img = {2'h0, attr1_hi, 2'h0, attr1_lo};
  assign map2_img = {2'h0, attr2_hi, 2'h0, attr2_lo};
  assign map3_img = {2'h0, attr3_hi, 2'h0, attr3_lo};

  // Straps come from pins and must be synchronised first
  hbdc_sync2 u_sync_serial_digital_video (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (serial_digital_video_strap_in),
    .sync_out   (serial_digital_video_sync)
  );

  hbdc_sync2 u_sync_conc (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (concurrent_op_strap_in),
    .sync_out   (conc_sync)
  );

  // Wait until synchronised straps are valid, then capture once
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
    end
    else if (!strap_done)
    begin
      if (strap_cnt == `HBDC_STRAP_WAIT)
        strap_done <= 1'b1;
      else
        strap_cnt <= strap_cnt + 2'h1;
    end
  end

  // Link root-complex base and its enable
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      link_rc_base      <= `HBDC_RST_RC_BASE_HI;
      link_rc_window_en <= 1'b0;
    end
    else if (wr_base)
    begin
      if (cfg_be_in[0])
        link_rc_window_en <= cfg_wdata_in[`HBDC_RC_EN_BIT];
      if (cfg_be_in[1])
        link_rc_base[3:0] <= cfg_wdata_in[15:12];
      if (cfg_be_in[2])
        link_rc_base[11:4] <= cfg_wdata_in[23:16];
      if (cfg_be_in[3])
        link_rc_base[19:12] <= cfg_wdata_in[31:24];
    end
  end

  // Graphics control; only software changes it, and never while smm_lock_in is high
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stolen_mem_size   <= `HBDC_RST_GFX_CTRL_GMS;
      vga_claim_disable <= 1'b0;
    end
    else if (wr_gfx && cfg_be_in[lane_of(`HBDC_OFF_GFX_CTRL)] &&
             !smm_lock_in)
    begin
      stolen_mem_size   <= cfg_wdata_in[16 + `HBDC_GMS_MSB:
                                        16 + `HBDC_GMS_LSB];
      vga_claim_disable <= cfg_wdata_in[16 + `HBDC_IVD_BIT];
    end
  end

  // Device enable; port bit is reloaded from straps once after reset
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      gfx_func1_enable <= `HBDC_RST_DEV_EN_F1;
      gfx_func0_enable <= `HBDC_RST_DEV_EN_F0;
      gfx_port_enable  <= `HBDC_RST_DEV_EN_PORT;
    end
    else
    begin
      if (wr_dev && cfg_be_in[0])
      begin
        gfx_func1_enable <= cfg_wdata_in[`HBDC_DEV_F1_BIT];
        gfx_func0_enable <= cfg_wdata_in[`HBDC_DEV_F0_BIT];
      end
      // Strap capture wins over a write in the same cycle
      if (!strap_done && strap_cnt == `HBDC_STRAP_WAIT)
        gfx_port_enable <= ~serial_digital_video_sync | conc_sync;
      else if (wr_dev && cfg_be_in[0])
        gfx_port_enable <= cfg_wdata_in[`HBDC_DEV_PORT_BIT];
    end
  end

  // Four attribute maps share one dword, one byte lane each
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      attr0_hi <= 2'h0;
      attr1_hi <= 2'h0;
      attr1_lo <= 2'h0;
      attr2_hi <= 2'h0;
      attr2_lo <= 2'h0;
      attr3_hi <= 2'h0;
      attr3_lo <= 2'h0;
    end
    else if (wr_map)
    begin
      if (cfg_be_in[lane_of(`HBDC_OFF_ATTR_MAP_0)])
        attr0_hi <= cfg_wdata_in[`HBDC_HI_MSB:`HBDC_HI_LSB];
      if (cfg_be_in[lane_of(`HBDC_OFF_ATTR_MAP_1)])
      begin
        attr1_hi <= cfg_wdata_in[8 + `HBDC_HI_MSB:8 + `HBDC_HI_LSB];
        attr1_lo <= cfg_wdata_in[8 + `HBDC_LO_MSB:8 + `HBDC_LO_LSB];
      end
      if (cfg_be_in[lane_of(`HBDC_OFF_ATTR_MAP_2)])
      begin
        attr2_hi <= cfg_wdata_in[16 + `HBDC_HI_MSB:16 + `HBDC_HI_LSB];
        attr2_lo <= cfg_wdata_in[16 + `HBDC_LO_MSB:16 + `HBDC_LO_LSB];
      end
      if (cfg_be_in[lane_of(`HBDC_OFF_ATTR_MAP_3)])
      begin
        attr3_hi <= cfg_wdata_in[24 + `HBDC_HI_MSB:24 + `HBDC_HI_LSB];
        attr3_lo <= cfg_wdata_in[24 + `HBDC_LO_MSB:24 + `HBDC_LO_LSB];
      end
    end
  end

  // Read path: one cycle latency, unmapped dwords read zero
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg_rdata_out    <= 32'h0000_0000;
      cfg_rd_valid_out <= 1'b0;
    end
    else
    begin
      cfg_rd_valid_out <= cfg_rd_in;
      if (cfg_rd_in)
      begin
        if (dw_hit(cfg_addr_in, `HBDC_OFF_RC_BASE))
          cfg_rdata_out <= rc_base_img;
        else if (dw_hit(cfg_addr_in, `HBDC_OFF_GFX_CTRL))
          cfg_rdata_out <= {gfx_ctrl_img, 16'h0000};
        else if (dw_hit(cfg_addr_in, `HBDC_OFF_DEV_EN))
          cfg_rdata_out <= dev_en_img;
        else if (dw_hit(cfg_addr_in, `HBDC_OFF_ATTR_MAP_0))
          cfg_rdata_out <= {map3_img, map2_img, map1_img, map0_img};
        else
          cfg_rdata_out <= 32'h0000_0000;
      end
    end
  end

  // Legacy segment steering for the access in flight
  hbdc_seg_steer u_seg_steer (
    .addr_in        (acc_addr_in),
    .write_in       (acc_write_in),
    .src_in         (acc_src_in),
    .map0_in        (map0_img),
    .map1_in        (map1_img),
    .map2_in        (map2_img),
    .map3_in        (map3_img),
    .legacy_hit_out (seg_legacy),
    .attr_known_out (seg_known),
    .to_dram_out    (seg_dram)
  );

  // Access decode, registered; hit results stand until the next access, done only follows acc_valid_in one cycle late
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      acc_done_out       <= 1'b0;
      rc_window_hit_out  <= 1'b0;
      legacy_hit_out     <= 1'b0;
      legacy_to_dram_out <= 1'b0;
      legacy_to_link_out <= 1'b0;
    end
    else
    begin
      acc_done_out <= acc_valid_in;
      if (acc_valid_in)
      begin
        // Window claims only while enabled, aligned to 4 KB
        rc_window_hit_out <= link_rc_window_en &&
          (acc_addr_in[`HBDC_RC_BASE_MSB:`HBDC_RC_BASE_LSB]
           == link_rc_base);
        legacy_hit_out     <= seg_legacy;
        // Link and port always land in memory; software keeps such
        // segments read-write so the host side never disagrees
        legacy_to_dram_out <= seg_dram;
        legacy_to_link_out <= seg_legacy & seg_known & ~seg_dram;
      end
    end
  end

  // VGA claiming is off when no memory is stolen or when disabled
  assign gfx_vga_off = (stolen_mem_size == `HBDC_GMS_NONE) |
                       vga_claim_disable;

  // Steering outputs, registered from the stored fields
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      vga_claim_out         <= 1'b0;
      gfx_subclass_out      <= `HBDC_SUBCLASS_VGA;
      stolen_mem_size_out   <= 3'h0;
      gfx_func0_visible_out <= 1'b0;
      gfx_func1_visible_out <= 1'b0;
      gfx_port_visible_out  <= 1'b0;
    end
    else
    begin
      vga_claim_out         <= ~gfx_vga_off;
      gfx_subclass_out      <= gfx_vga_off ? `HBDC_SUBCLASS_OTHER
                                           : `HBDC_SUBCLASS_VGA;
      stolen_mem_size_out   <= stolen_mem_size;
      gfx_func0_visible_out <= gfx_func0_enable;
      gfx_func1_visible_out <= gfx_func1_enable;
      gfx_port_visible_out  <= gfx_port_enable;
    end
  end

endmodule

/* File: design/hbdc_defines.vh */
`ifndef HBDC_DEFINES_VH
`define HBDC_DEFINES_VH

// Configuration offsets (bus 0, device 0, function 0)
`define HBDC_OFF_RC_BASE      8'h4c
`define HBDC_OFF_GFX_CTRL     8'h52
`define HBDC_OFF_DEV_EN       8'h54
`define HBDC_OFF_ATTR_MAP_0   8'h90
`define HBDC_OFF_ATTR_MAP_1   8'h91
`define HBDC_OFF_ATTR_MAP_2   8'h92
`define HBDC_OFF_ATTR_MAP_3   8'h93

// Reset values
`define HBDC_RST_RC_BASE      32'h0000_0000
`define HBDC_RST_GFX_CTRL     16'h0030
`define HBDC_RST_DEV_EN       32'h0000_001b
`define HBDC_RST_ATTR_MAP     8'h00

// Link root-complex base fields
`define HBDC_RC_BASE_MSB      31
`define HBDC_RC_BASE_LSB      12
`define HBDC_RC_EN_BIT        0

// Graphics control fields
`define HBDC_GMS_MSB          6
`define HBDC_GMS_LSB          4
`define HBDC_IVD_BIT          1
`define HBDC_GMS_NONE         3'h0
`define HBDC_GMS_1MB          3'h1
`define HBDC_GMS_8MB          3'h3
`define HBDC_SUBCLASS_VGA     8'h00
`define HBDC_SUBCLASS_OTHER   8'h80

// Device enable fields
`define HBDC_DEV_F1_BIT       4
`define HBDC_DEV_F0_BIT       3
`define HBDC_DEV_PORT_BIT     1
`define HBDC_DEV_HOST_BIT     0

// Segment attribute fields and encodings
`define HBDC_HI_MSB           5
`define HBDC_HI_LSB           4
`define HBDC_LO_MSB           1
`define HBDC_LO_LSB           0
`define HBDC_ATTR_RE_BIT      0
`define HBDC_ATTR_WE_BIT      1

// Legacy region 0C0000h-0FFFFFh and 16-KB segment index
`define HBDC_LEG_TOP_MSB      31
`define HBDC_LEG_TOP_LSB      18
`define HBDC_LEG_TOP_VAL      14'h0003
`define HBDC_SEG_MSB          17
`define HBDC_SEG_LSB          14
`define HBDC_SEG_C0           4'h0
`define HBDC_SEG_C4           4'h1
`define HBDC_SEG_C8           4'h2
`define HBDC_SEG_CC           4'h3
`define HBDC_SEG_D0           4'h4
`define HBDC_SEG_D4           4'h5
`define HBDC_SEG_F0_HI2       2'h3

// Access sources
`define HBDC_SRC_HOST         2'h0
`define HBDC_SRC_PCI          2'h1
`define HBDC_SRC_LINK         2'h2
`define HBDC_SRC_GFX          2'h3

// Cycles after reset release before straps are trusted
`define HBDC_STRAP_WAIT       2'h2

`endif

/* File: design/hbdc_sync2.v */
module hbdc_sync2 (
  input  wire       clk_sys_in,
  input  wire       rst_in,
  input  wire       async_in,
  output reg        sync_out
);

  reg stage1;

  // Two flops; only the second flop reads the first
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* File: design/hbdc_seg_steer.v */
`include "hbdc_defines.vh"

module hbdc_seg_steer (
  input  wire [31:0] addr_in,
  input  wire        write_in,
  input  wire [1:0]  src_in,
  input  wire [7:0]  map0_in,
  input  wire [7:0]  map1_in,
  input  wire [7:0]  map2_in,
  input  wire [7:0]  map3_in,
  output wire        legacy_hit_out,
  output wire        attr_known_out,
  output wire        to_dram_out
);

  wire [3:0] seg;
  reg  [1:0] attr;
  reg        known;

  assign seg = addr_in[`HBDC_SEG_MSB:`HBDC_SEG_LSB];
  // Whole 0C0000h-0FFFFFh window
  assign legacy_hit_out =
    (addr_in[`HBDC_LEG_TOP_MSB:`HBDC_LEG_TOP_LSB] == `HBDC_LEG_TOP_VAL);

  // Pick the two-bit attribute of the addressed 16-KB segment
  always @*
  begin
    attr  = 2'h0;
    known = 1'b1;
    case (seg)
      `HBDC_SEG_C0: attr = map1_in[`HBDC_LO_MSB:`HBDC_LO_LSB];
      `HBDC_SEG_C4: attr = map1_in[`HBDC_HI_MSB:`HBDC_HI_LSB];
      `HBDC_SEG_C8: attr = map2_in[`HBDC_LO_MSB:`HBDC_LO_LSB];
      `HBDC_SEG_CC: attr = map2_in[`HBDC_HI_MSB:`HBDC_HI_LSB];
      `HBDC_SEG_D0: attr = map3_in[`HBDC_LO_MSB:`HBDC_LO_LSB];
      `HBDC_SEG_D4: attr = map3_in[`HBDC_HI_MSB:`HBDC_HI_LSB];
      default:
      begin
        if (seg[3:2] == `HBDC_SEG_F0_HI2)
          attr = map0_in[`HBDC_HI_MSB:`HBDC_HI_LSB];
        else
          known = 1'b0;
      end
    endcase
  end

  assign attr_known_out = legacy_hit_out & known;

  // Link and graphics-port initiators always go to memory; host and PCI obey
  // the attribute, read enable for reads and write enable for writes
  assign to_dram_out = legacy_hit_out &
    (((src_in == `HBDC_SRC_LINK) | (src_in == `HBDC_SRC_GFX)) |
     (known & (write_in ? attr[`HBDC_ATTR_WE_BIT]
                        : attr[`HBDC_ATTR_RE_BIT])));

endmodule

/* File: design/hbdc_rst_defines.vh */
`ifndef HBDC_RST_DEFINES_VH
`define HBDC_RST_DEFINES_VH

// Per-field reset values of the stored register bits
`define HBDC_RST_RC_BASE_HI   20'h0_0000
`define HBDC_RST_GFX_CTRL_GMS 3'h3
`define HBDC_RST_DEV_EN_F1    1'h1
`define HBDC_RST_DEV_EN_F0    1'h1
// Port enable holds one until the straps have been captured
`define HBDC_RST_DEV_EN_PORT  1'h1

`endif

/* File: bench/hbdc_monitor.sv */
module hbdc_monitor (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        cfg_wr_in,
  input wire logic        cfg_rd_in,
  input wire logic [7:0]  cfg_addr_in,
  input wire logic [3:0]  cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic        cfg_rd_valid_out,
  input wire logic        smm_lock_in,
  input wire logic        acc_valid_in,
  input wire logic [31:0] acc_addr_in,
  input wire logic        acc_write_in,
  input wire logic [1:0]  acc_src_in,
  input wire logic        acc_done_out,
  input wire logic        rc_window_hit_out,
  input wire logic        legacy_hit_out,
  input wire logic        legacy_to_dram_out,
  input wire logic        legacy_to_link_out,
  input wire logic        vga_claim_out,
  input wire logic [7:0]  gfx_subclass_out,
  input wire logic [2:0]  stolen_mem_size_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rc_shadow;
  logic [31:0] map_shadow;
  logic [31:0] next_rc_shadow;
  logic [31:0] next_map_shadow;
  logic [1:0]  seg_attr;
  logic        seg_covered;
  logic        steer_dram;
  logic        window_match;

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] be);
    lane_merge = old;
    for (int i = 0; i < 4; i++)
      if (be[i]) lane_merge[8*i +: 8] = data[8*i +: 8];
  endfunction

  // Shadow of the window and attribute dwords, only the writable fields kept
  always_comb
  begin
    next_rc_shadow = rc_shadow;
    next_map_shadow = map_shadow;
    if (cfg_wr_in && cfg_addr_in[7:2] == 6'h13)
      next_rc_shadow = lane_merge(rc_shadow, cfg_wdata_in, cfg_be_in) & 32'hffff_f001;
    if (cfg_wr_in && cfg_addr_in[7:2] == 6'h24)
      next_map_shadow = lane_merge(map_shadow, cfg_wdata_in, cfg_be_in) & 32'h3333_3330;
  end

  // Shadow registers, cleared like the block's own
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rc_shadow <= 32'h0000_0000;
      map_shadow <= 32'h0000_0000;
    end
    else
    begin
      rc_shadow <= next_rc_shadow;
      map_shadow <= next_map_shadow;
    end
  end

  // Expected decode; segment index only meaningful inside the covered range
  always_comb
  begin
    seg_covered = acc_addr_in[31:18] == 14'h0003 &&
                  (acc_addr_in[17:14] < 4'h6 || acc_addr_in[17:16] == 2'h3);
    seg_attr = (acc_addr_in[17:16] == 2'h3) ? map_shadow[5:4] :
               map_shadow[8 + 4 * acc_addr_in[17:14] +: 2];
    steer_dram = acc_write_in ? seg_attr[1] : seg_attr[0];
    window_match = rc_shadow[0] && acc_addr_in[31:12] == rc_shadow[31:12];
  end

  default clocking mon_clk @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  rc_reserved_a: assert property (cfg_rd_in && cfg_addr_in[7:2] == 6'h13 |=>
    cfg_rd_valid_out && cfg_rdata_out[11:1] == 11'h000) else $error("window reserved set");
  gfx_reserved_a: assert property (cfg_rd_in && cfg_addr_in[7:2] == 6'h14 |=>
    (cfg_rdata_out & 32'hff8d_ffff) == 32'h0000_0000) else $error("gfx reserved set");
  host_always_on_a: assert property (cfg_rd_in && cfg_addr_in[7:2] == 6'h15 |=>
    cfg_rdata_out[0] && (cfg_rdata_out & 32'hffff_ffe4) == 32'h0000_0000)
    else $error("device enable bit 0 not one");
  map_reserved_a: assert property (cfg_rd_in && cfg_addr_in[7:2] == 6'h24 |=>
    (cfg_rdata_out & 32'hcccc_cccf) == 32'h0000_0000) else $error("map reserved set");
  vga_subclass_a: assert property (!$past(rst_in) |->
    vga_claim_out != (gfx_subclass_out == 8'h80)) else $error("claim and subclass disagree");
  no_stolen_a: assert property (!$past(rst_in) && stolen_mem_size_out == 3'h0 |->
    !vga_claim_out && gfx_subclass_out == 8'h80) else $error("size zero still claims");
  locked_gfx_a: assert property (smm_lock_in && cfg_wr_in && cfg_addr_in[7:2] == 6'h14 |=>
    ##1 $stable(stolen_mem_size_out) && $stable(vga_claim_out)) else $error("locked write took");
  window_hit_a: assert property (acc_valid_in |=>
    acc_done_out && rc_window_hit_out == $past(window_match)) else $error("window hit wrong");
  remote_dram_a: assert property (acc_valid_in && acc_src_in[1] &&
    acc_addr_in[31:18] == 14'h0003 |=> legacy_hit_out && legacy_to_dram_out && !legacy_to_link_out)
    else $error("link access not sent to memory");
  seg_steer_a: assert property (acc_valid_in && !acc_src_in[1] && seg_covered |=>
    legacy_to_dram_out == $past(steer_dram) && legacy_to_link_out == !$past(steer_dram))
    else $error("segment steering wrong");

  cover property (acc_valid_in && window_match);
  cover property (smm_lock_in && cfg_wr_in && cfg_addr_in[7:2] == 6'h14);
  cover property (acc_valid_in && acc_src_in[1] && seg_covered);
  cover property (acc_valid_in && !acc_src_in[1] && seg_covered && acc_write_in && steer_dram);
endmodule

bind hbdc_host_bridge hbdc_monitor hbdc_monitor_inst (
  .clk_sys_in, .rst_in, .cfg_wr_in, .cfg_rd_in, .cfg_addr_in, .cfg_be_in, .cfg_wdata_in,
  .cfg_rdata_out, .cfg_rd_valid_out, .smm_lock_in, .acc_valid_in, .acc_addr_in, .acc_write_in,
  .acc_src_in, .acc_done_out, .rc_window_hit_out, .legacy_hit_out, .legacy_to_dram_out,
  .legacy_to_link_out, .vga_claim_out, .gfx_subclass_out, .stolen_mem_size_out
);

/* File: bench/host_bridge_decode_config_test.sv */
module host_bridge_decode_config_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_in, rst_in, cfg_wr_in, cfg_rd_in, smm_lock_in, acc_valid_in, acc_write_in;
  logic        serial_digital_video_strap_in, concurrent_op_strap_in;
  logic [7:0]  cfg_addr_in;
  logic [3:0]  cfg_be_in;
  logic [31:0] cfg_wdata_in, acc_addr_in, cfg_rdata_out;
  logic [1:0]  acc_src_in;
  logic        cfg_rd_valid_out, acc_done_out, rc_window_hit_out, legacy_hit_out;
  logic        legacy_to_dram_out, legacy_to_link_out, vga_claim_out;
  logic        gfx_func0_visible_out, gfx_func1_visible_out, gfx_port_visible_out;
  logic [7:0]  gfx_subclass_out;
  logic [2:0]  stolen_mem_size_out;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cycles = 0;

  hbdc_host_bridge hbdc_host_bridge_inst (
    .clk_sys_in, .rst_in, .cfg_wr_in, .cfg_rd_in, .cfg_addr_in, .cfg_be_in, .cfg_wdata_in,
    .cfg_rdata_out, .cfg_rd_valid_out, .smm_lock_in, .serial_digital_video_strap_in,
    .concurrent_op_strap_in, .acc_valid_in, .acc_addr_in, .acc_write_in, .acc_src_in,
    .acc_done_out, .rc_window_hit_out, .legacy_hit_out, .legacy_to_dram_out,
    .legacy_to_link_out, .vga_claim_out, .gfx_subclass_out, .stolen_mem_size_out,
    .gfx_func0_visible_out, .gfx_func1_visible_out, .gfx_port_visible_out
  );

  // 250 MHz clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // Hang guard: the whole sequence needs only about 700 cycles
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Straps are sampled after release, so they are set before reset drops
  task automatic do_reset(input logic [1:0] straps);
    @(posedge clk_sys_in);
    #1;
    {concurrent_op_strap_in, serial_digital_video_strap_in} = straps;
    rst_in = 1'b1;
    repeat (20) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    repeat (6) @(posedge clk_sys_in);
  endtask

  task automatic cfg_write(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] data);
    @(posedge clk_sys_in);
    #1;
    {cfg_wr_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} = {1'b1, addr, be, data};
    @(posedge clk_sys_in);
    #1;
    cfg_wr_in = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic read_check(input logic [7:0] addr, input logic [31:0] exp);
    @(posedge clk_sys_in);
    #1;
    {cfg_rd_in, cfg_addr_in} = {1'b1, addr};
    @(posedge clk_sys_in);
    #1;
    cfg_rd_in = 1'b0;
    check_word({31'h0, cfg_rd_valid_out}, 32'h0000_0001);
    check_word(cfg_rdata_out, exp);
  endtask

  // Result packed as done, legacy hit, to memory, to link, window hit
  task automatic access_check(input logic [31:0] addr, input logic wr, input logic [1:0] src,
                              input logic [3:0] exp);
    @(posedge clk_sys_in);
    #1;
    {acc_valid_in, acc_addr_in, acc_write_in, acc_src_in} = {1'b1, addr, wr, src};
    @(posedge clk_sys_in);
    #1;
    acc_valid_in = 1'b0;
    check_word({27'h0, acc_done_out, legacy_hit_out, legacy_to_dram_out, legacy_to_link_out,
                rc_window_hit_out}, {28'h1, exp});
  endtask

  // Steering packed as claim, subclass, size, function 0, function 1, port
  task automatic outs_check(input logic [14:0] exp);
    check_word({17'h0, vga_claim_out, gfx_subclass_out, stolen_mem_size_out,
                gfx_func0_visible_out, gfx_func1_visible_out, gfx_port_visible_out}, {17'h0, exp});
  endtask

  initial
  begin
    logic [31:0] fields;
    logic [1:0]  code;
    logic        dram;
    logic [31:0] seg_addr;
    {cfg_wr_in, cfg_rd_in, smm_lock_in, acc_valid_in, acc_write_in} = 5'h00;
    {cfg_addr_in, cfg_be_in, cfg_wdata_in, acc_addr_in, acc_src_in} = 78'h0;
    rst_in = 1'b1;
    do_reset(2'h0);
    // Reset contents and steering
    read_check(8'h4c, 32'h0000_0000);
    read_check(8'h50, 32'h0030_0000);
    read_check(8'h54, 32'h0000_001b);
    read_check(8'h90, 32'h0000_0000);
    read_check(8'h60, 32'h0000_0000);
    outs_check(15'h401f);
    // Window base and enable
    cfg_write(8'h4c, 4'hf, 32'hffff_ffff);
    read_check(8'h4c, 32'hffff_f001);
    access_check(32'hffff_f000, 1'b0, 2'h0, 4'h1);
    access_check(32'hffff_effc, 1'b1, 2'h2, 4'h0);
    cfg_write(8'h4c, 4'h1, 32'h0000_0000);
    access_check(32'hffff_f800, 1'b0, 2'h0, 4'h0);
    // Graphics control codes, reserved bits and lock
    cfg_write(8'h50, 4'hc, 32'h0000_0000);
    outs_check(15'h2007);
    cfg_write(8'h50, 4'hc, 32'hffff_ffff);
    read_check(8'h50, 32'h0072_0000);
    cfg_write(8'h50, 4'hc, 32'h0012_0000);
    outs_check(15'h200f);
    cfg_write(8'h50, 4'hc, 32'h0010_0000);
    outs_check(15'h400f);
    smm_lock_in = 1'b1;
    cfg_write(8'h50, 4'hc, 32'h0032_0000);
    read_check(8'h50, 32'h0010_0000);
    smm_lock_in = 1'b0;
    // Device enables; graphics control must not follow them
    cfg_write(8'h54, 4'hf, 32'h0000_0000);
    read_check(8'h54, 32'h0000_0001);
    outs_check(15'h4008);
    read_check(8'h50, 32'h0010_0000);
    cfg_write(8'h54, 4'hf, 32'hffff_ffff);
    read_check(8'h54, 32'h0000_001b);
    // Segment i gets code (i + k) mod 4, rotated so every field sees every code
    for (int k = 0; k < 4; k++)
    begin
      fields = 32'h0000_0000;
      for (int i = 0; i < 7; i++)
        fields[(i == 6 ? 4 : 8 + 4 * i) +: 2] = 2'((i + k) % 4);
      cfg_write(8'h90, 4'hf, ~32'h3333_3330 | fields);
      read_check(8'h90, fields);
      for (int i = 0; i < 7; i++)
        for (int a = 0; a < 8; a++)
        begin
          code = 2'((i + k) % 4);
          dram = (a >= 4) | (a[0] ? code[1] : code[0]);
          seg_addr = (i == 6) ? 32'h000f_0000 + k * 32'h4000
                              : 32'h000c_0000 + i * 32'h4000 + k * 32'h0ffc;
          access_check(seg_addr, a[0], 2'(a >> 1), {1'b1, dram, !dram, 1'b0});
        end
    end
    cfg_write(8'h90, 4'h4, 32'h0000_0000);
    read_check(8'h90, fields & 32'hff00_ffff);
    access_check(32'h000d_8000, 1'b0, 2'h0, 4'h8);
    access_check(32'h000e_4000, 1'b1, 2'h3, 4'hc);
    access_check(32'h0010_0000, 1'b0, 2'h0, 4'h0);
    // Software opens the top segment fully before the link touches it
    cfg_write(8'h90, 4'h1, 32'h0000_0030);
    access_check(32'h000f_8000, 1'b0, 2'h2, 4'hc);
    access_check(32'h000f_8000, 1'b1, 2'h0, 4'hc);
    // Port enable reset value follows both straps
    for (int s = 0; s < 4; s++)
    begin
      do_reset(2'(s));
      read_check(8'h54, {28'h001, 2'b10, !s[0] | s[1], 1'b1});
    end
    give_verdict();
  end
endmodule
